// ===== hdl/reqa_chan.sv
`timescale 1ns/10ps
module reqa_chan
   import reqa_pkg::*;
#(
   parameter int PW = PWR_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Accumulation control
   input wire logic tick,
   input wire logic signed [PW-1:0] pwr,
   input wire logic [7:0] thr,
   input wire logic [1:0] mode,
   input wire logic lc_en,
   input wire logic lc_done,
   input wire logic rd_clr,
   // Results
   output logic [31:0] hr,
   output logic half_ev
);
   typedef struct packed {
      logic signed [ACC_W-1:0] acc;
      logic [31:0] cnt;
      logic [31:0] hold;
      logic half;
   } reqa_chan_t;

   reqa_chan_t s_r;
   reqa_chan_t s_nxt;
   logic signed [ACC_W-1:0] p;
   logic signed [ACC_W-1:0] th;
   logic signed [ACC_W-1:0] a;
   logic signed [1:0] inc;
   logic [31:0] inc32;
   logic [31:0] c;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.half = 1'b0;
      inc = 2'sd0;
      case (mode)
         ACCM_POS: p = (pwr < 0) ? '0 : ACC_W'(pwr);
         ACCM_ABS: p = (pwr < 0) ? -ACC_W'(pwr) : ACC_W'(pwr);
         default: p = ACC_W'(pwr);
      endcase
      th = {{(ACC_W-8-THR_SHIFT){1'b0}}, thr, {THR_SHIFT{1'b0}}};
      a = s_r.acc;
      if (tick)
      begin
         a = s_r.acc + p;
         if (a >= th)
         begin
            a = a - th;
            inc = 2'sd1;
         end
         else if (a <= -th)
         begin
            a = a + th;
            inc = -2'sd1;
         end
      end
      s_nxt.acc = a;
      inc32 = {{30{inc[1]}}, inc};
      c = s_r.cnt + inc32;
      if (rd_clr)
      begin
         // A pulse in the clearing cycle is kept, not dropped
         s_nxt.cnt = inc32;
         s_nxt.hold = '0;
      end
      else if (lc_en && lc_done)
      begin
         s_nxt.hold = c;
         s_nxt.cnt = '0;
         s_nxt.half = c[30] ^ s_r.hold[30];
      end
      else
      begin
         s_nxt.cnt = c;
         s_nxt.half = !lc_en && (c[30] ^ s_r.cnt[30]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign hr = lc_en ? s_r.hold : s_r.cnt;
   assign half_ev = s_r.half;
endmodule : reqa_chan

// ===== hdl/reqa_lcyc.sv
`timescale 1ns/10ps
module reqa_lcyc
   import reqa_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Zero crossings and setup
   input wire logic [2:0] zx,
   input wire logic [2:0] zx_sel,
   input wire logic en,
   input wire logic [HCC_W-1:0] target,
   // Period end
   output logic done
);
   typedef struct packed {
      logic [HCC_W-1:0] cnt;
      logic done;
   } reqa_lcyc_t;

   reqa_lcyc_t s_r;
   reqa_lcyc_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!en)
         s_nxt.cnt = '0;
      else if (|(zx & zx_sel))
      begin
         if (s_r.cnt + 1'b1 >= target)
         begin
            // Restart at once so periods abut
            s_nxt.cnt = '0;
            s_nxt.done = 1'b1;
         end
         else
            s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign done = s_r.done;
endmodule : reqa_lcyc

// ===== hdl/reqa_pkg.sv
package reqa_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int PWR_W = 28;
   localparam int ACC_W = 38;
   localparam int THR_SHIFT = 27;
   localparam int HCC_W = 16;
   localparam int PH_W = 16;
   localparam int ADDR_W = 8;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [PH_W-1:0] CLK_KHZ = 16'h4e20;
   localparam logic [PH_W-1:0] ACC_KHZ = 16'h0400;
   localparam real ACC_PERIOD_NS = 976.5625;
   localparam real CLK_PERIOD_NS = 50.0;
   localparam int ACC_CYC = $rtoi(ACC_PERIOD_NS / CLK_PERIOD_NS);
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_THR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HR0 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_LCMODE = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_ACCUMULATION_MODE_REGISTER = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_HCC = 8'h2c;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int ST_TOT_BIT = 2;
   localparam int ST_FUND_BIT = 3;
   localparam int LC_EN_BIT = 1;
   localparam int ZX_LSB = 3;
   localparam int RDCLR_BIT = 6;
   localparam int REACTIVE_ACCUMULATION_SELECT_LSB = 2;
   localparam int CONNECTION_SELECT_LSB = 4;
   localparam logic [7:0] THR_RST = 8'h03;
   localparam logic [HCC_W-1:0] HCC_RST = 16'h0064;
   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam logic [1:0] ACCM_POS = 2'h1;
   localparam logic [1:0] ACCM_ABS = 2'h2;
   localparam logic [1:0] CON_DELTA = 2'h1;
   localparam logic [1:0] CON_NEG_A = 2'h3;
endpackage : reqa_pkg

// ===== hdl/reqa_top.sv
// Contract
// - Threshold is unsigned 8 bits, maximum 255, reset value three.
// - First stage adds latest power each accumulation tick; samples arrive at 8 kHz.
// - Six signed 32-bit var-hour registers: three total, three fundamental.
// - Var-hour registers wrap between most positive and most negative.
// - Total half-full flag set when bit 30 of a total register toggles.
// - Fundamental half-full flag, status bit 3, same for fundamental registers.
// - Mask bits 3 and 2 let the flags pull the interrupt low.
// - Writing one to a status bit clears it and releases interrupt.
// - With clear-on-read set, a var-hour register reads then becomes zero.
// - Accumulation sample period is 976.5625 ns.
// - Connection select picks phase B input: normal, A minus C, minus A.
// - Reactive accumulation field chooses how power is accumulated.
// - Line-cycle mode moves accumulators to registers after set half cycles.
// - Line-cycle accumulation active while line-cycle mode bit 1 set.
// - Three select bits choose which phases' zero crossings count.
// - First stage at threshold emits a pulse and subtracts the threshold.
// - Effective threshold is the setting followed by 27 zero bits.
// - Second stage counts pulses in 32-bit accumulators shown on access.
`timescale 1ns/10ps
module reqa_top
   import reqa_pkg::*;
#(
   parameter int PW = PWR_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instantaneous reactive power, total
   input wire logic sample_valid,
   input wire logic signed [PW-1:0] q_tot_a,
   input wire logic signed [PW-1:0] q_tot_b,
   input wire logic signed [PW-1:0] q_tot_c,
   input wire logic signed [PW-1:0] q_tot_ab,
   input wire logic signed [PW-1:0] q_tot_cb,
   // Instantaneous reactive power, fundamental
   input wire logic signed [PW-1:0] q_fund_a,
   input wire logic signed [PW-1:0] q_fund_b,
   input wire logic signed [PW-1:0] q_fund_c,
   input wire logic signed [PW-1:0] q_fund_ab,
   input wire logic signed [PW-1:0] q_fund_cb,
   // Zero crossings, phases C B A
   input wire logic [2:0] zero_cross,
   // Interrupt
   output logic primary_interrupt_n
);
   localparam int TICK_MIN = ACC_CYC;
   localparam int TICK_MAX = ACC_CYC + 1;

   typedef struct packed {
      logic [7:0] thr;
      logic [1:0] st;
      logic [1:0] mask;
      logic clr_en;
      logic lc_en;
      logic [2:0] zero_cross_phase_select;
      logic [1:0] connection_select;
      logic [1:0] reactive_accumulation_select;
      logic [HCC_W-1:0] hcc;
      logic [PH_W-1:0] ph;
      logic tick;
      logic [9:0][PW-1:0] lat;
      logic [31:0] rdata;
   } reqa_top_t;

   reqa_top_t s_r;
   reqa_top_t s_nxt;

   logic setup;
   logic acc_wr;
   logic hit;
   logic [31:0] rd_val;
   logic [PH_W-1:0] ph_sum;
   logic [1:0] st_clr;
   logic [5:0] rd_clr;
   logic [5:0] half;
   logic [2:0] tot_half;
   logic [2:0] fund_half;
   logic lc_done;
   logic [31:0] hr_v [6];
   logic signed [PW-1:0] pw [6];

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pwrite;
   assign pready = psel && penable;
   assign pslverr = pready && !hit;
   assign prdata = s_r.rdata;
   assign tot_half = half[2:0];
   assign fund_half = half[5:3];

   always_comb
   begin
      hit = 1'b1;
      rd_val = '0;
      rd_clr = '0;
      case (paddr)
         OFS_THR: rd_val = {24'h000000, s_r.thr};
         OFS_STATUS: rd_val = {28'h0000000, s_r.st, 2'h0};
         OFS_MASK: rd_val = {28'h0000000, s_r.mask, 2'h0};
         OFS_LCMODE: rd_val = {25'h0000000, s_r.clr_en, s_r.zero_cross_phase_select, 1'b0, s_r.lc_en, 1'b0};
         OFS_ACCUMULATION_MODE_REGISTER: rd_val = {26'h0000000, s_r.connection_select, s_r.reactive_accumulation_select, 2'h0};
         OFS_HCC: rd_val = {16'h0000, s_r.hcc};
         default:
         begin
            hit = 1'b0;
            for (int i = 0; i < 6; i++)
            begin
               if (paddr == OFS_HR0 + ADDR_W'(4 * i))
               begin
                  hit = 1'b1;
                  rd_val = hr_v[i];
                  rd_clr[i] = setup && !pwrite && s_r.clr_en;
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // Phase B input by wiring
   // ----------------------------------------
   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         pw[3 * k] = $signed(s_r.lat[5 * k]);
         pw[3 * k + 2] = $signed(s_r.lat[5 * k + 2]);
         case (s_r.connection_select)
            CON_DELTA: pw[3 * k + 1] = PW'($signed(s_r.lat[5 * k + 3]) - $signed(s_r.lat[5 * k + 4]));
            CON_NEG_A: pw[3 * k + 1] = PW'(-$signed(s_r.lat[5 * k + 3]));
            default: pw[3 * k + 1] = $signed(s_r.lat[5 * k + 1]);
         endcase
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      // Fractional divider: 1024 ticks per 20000 clocks, exact on average
      ph_sum = s_r.ph + ACC_KHZ;
      s_nxt.tick = ph_sum >= CLK_KHZ;
      s_nxt.ph = s_nxt.tick ? ph_sum - CLK_KHZ : ph_sum;
      if (sample_valid)
      begin
         // Held until next sample, so every tick re-adds it
         s_nxt.lat = {q_fund_cb, q_fund_ab, q_fund_c, q_fund_b, q_fund_a,
                      q_tot_cb, q_tot_ab, q_tot_c, q_tot_b, q_tot_a};
      end
      if (setup && !pwrite)
         s_nxt.rdata = rd_val;
      st_clr = '0;
      if (acc_wr)
      begin
         case (paddr)
            OFS_THR: s_nxt.thr = pwdata[7:0];
            OFS_STATUS: st_clr = {pwdata[ST_FUND_BIT], pwdata[ST_TOT_BIT]};
            OFS_MASK: s_nxt.mask = {pwdata[ST_FUND_BIT], pwdata[ST_TOT_BIT]};
            OFS_LCMODE:
            begin
               s_nxt.lc_en = pwdata[LC_EN_BIT];
               s_nxt.zero_cross_phase_select = pwdata[ZX_LSB +: 3];
               s_nxt.clr_en = pwdata[RDCLR_BIT];
            end
            OFS_ACCUMULATION_MODE_REGISTER:
            begin
               s_nxt.reactive_accumulation_select = pwdata[REACTIVE_ACCUMULATION_SELECT_LSB +: 2];
               s_nxt.connection_select = pwdata[CONNECTION_SELECT_LSB +: 2];
            end
            OFS_HCC: s_nxt.hcc = pwdata[HCC_W-1:0];
            default: st_clr = '0;
         endcase
      end
      // A new event in the clearing cycle wins over the clear
      s_nxt.st = (s_r.st & ~st_clr) | {|fund_half, |tot_half};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
         s_r.thr <= THR_RST;
         s_r.hcc <= HCC_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign primary_interrupt_n = !(|(s_r.st & s_r.mask));

   // ----------------------------------------
   // Energy channels
   // ----------------------------------------
   for (genvar g = 0; g < 6; g++)
   begin : g_chan
      reqa_chan #(
         .PW(PW)
      ) u_chan (
         .pclk(pclk),
         .presetn(presetn),
         .tick(s_r.tick),
         .pwr(pw[g]),
         .thr(s_r.thr),
         .mode(s_r.reactive_accumulation_select),
         .lc_en(s_r.lc_en),
         .lc_done(lc_done),
         .rd_clr(rd_clr[g]),
         .hr(hr_v[g]),
         .half_ev(half[g])
      );
   end

   reqa_lcyc u_lcyc (
      .pclk(pclk),
      .presetn(presetn),
      .zx(zero_cross),
      .zx_sel(s_r.zero_cross_phase_select),
      .en(s_r.lc_en),
      .target(s_r.hcc),
      .done(lc_done)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_thr_wr;
      acc_wr && paddr == OFS_THR |=> s_r.thr == 8'($past(pwdata));
   endproperty
   a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost");

   property p_tick_gap;
      s_r.tick |=> (!s_r.tick)[*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

   property p_tick_next;
      s_r.tick |-> ##[TICK_MIN:TICK_MAX] s_r.tick;
   endproperty
   a_tick_next: assert property (p_tick_next) else $error("tick period wrong");

   property p_tot_half;
      |tot_half |=> s_r.st[0];
   endproperty
   a_tot_half: assert property (p_tot_half) else $error("total half flag missed");

   property p_fund_half;
      |fund_half |=> s_r.st[1];
   endproperty
   a_fund_half: assert property (p_fund_half) else $error("fund half flag missed");

   property p_irq;
      |fund_half && s_r.mask[1] |=> !primary_interrupt_n;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not asserted");

   property p_st_clr;
      acc_wr && paddr == OFS_STATUS && pwdata[ST_TOT_BIT] && !(|tot_half) && !s_r.mask[1]
         |=> !s_r.st[0] && (s_r.mask[0] -> primary_interrupt_n);
   endproperty
   a_st_clr: assert property (p_st_clr) else $error("status clear failed");

   property p_rdclr;
      setup && !pwrite && s_r.clr_en && paddr == OFS_HR0 |=> hr_v[0] + 32'h1 <= 32'h2;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("read clear failed");

   property p_connection_select;
      s_r.connection_select == CON_NEG_A && $stable(s_r.lat) |-> pw[1] == PW'(-$signed(s_r.lat[3]));
   endproperty
   a_connection_select: assert property (p_connection_select) else $error("phase B select wrong");

   c_tick: cover property (s_r.tick);
   c_half: cover property (|tot_half);
   c_lcdone: cover property (lc_done && s_r.lc_en);
   c_rdclr: cover property (|rd_clr);
endmodule : reqa_top

// ===== verification/reactive_energy_accumulator_test.sv
`timescale 1ns/10ps
module reactive_energy_accumulator_test;
   import reqa_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   localparam int WIN = 2000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, err, sample_valid;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [PWR_W-1:0] qt [5];
   logic signed [PWR_W-1:0] qf [5];
   logic [2:0] zero_cross;
   logic [31:0] seed = 32'hf597a440;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [ADDR_W-1:0] wofs [7] = '{OFS_THR, OFS_MASK, OFS_LCMODE, OFS_ACCUMULATION_MODE_REGISTER, OFS_HCC, OFS_STATUS, OFS_HR0};
   logic [31:0] wexp [7] = '{32'hff, 32'hc, 32'h7a, 32'h3c, 32'hffff, 32'h0, 32'h0};

   reqa_top dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .q_tot_a(qt[0]), .q_tot_b(qt[1]), .q_tot_c(qt[2]),
      .q_tot_ab(qt[3]), .q_tot_cb(qt[4]), .q_fund_a(qf[0]), .q_fund_b(qf[1]), .q_fund_c(qf[2]),
      .q_fund_ab(qf[3]), .q_fund_cb(qf[4]), .zero_cross(zero_cross), .primary_interrupt_n(irq_n)
   );

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Pulses expected over the window; tick jitter and residue stay inside the tolerance
   function automatic int ecnt(input int p, input int thr);
      return $rtoi(WIN * real'(ACC_KHZ) / real'(CLK_KHZ) * p / (thr * 2.0 ** THR_SHIFT));
   endfunction : ecnt

   function automatic logic near(input int g, input int e);
      return (g - e <= 3) && (e - g <= 3);
   endfunction : near

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         results();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // Fundamental inputs carry the negated total so both paths see both signs
   task automatic set_pwr(input int v[5]);
      foreach (v[i])
      begin
         qt[i] <= PWR_W'(v[i]);
         qf[i] <= PWR_W'(-v[i]);
      end
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
   endtask : set_pwr

   // Relies on clear-on-read: first pass empties, second pass reads the window
   task automatic measure(output int g[5]);
      for (int i = 0; i < 5; i++)
         apb(1'b0, OFS_HR0 + ADDR_W'(4 * i), 32'h0);
      repeat (WIN) @(posedge pclk);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, OFS_HR0 + ADDR_W'(4 * i), 32'h0);
         g[i] = rd;
      end
   endtask : measure

   task automatic zx(input logic [2:0] b, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         zero_cross <= b;
         @(posedge pclk);
         zero_cross <= 3'h0;
         repeat (300) @(posedge pclk);
      end
   endtask : zx

   initial
   begin
      repeat (90000) @(posedge pclk);
      error_cnt++;
      results();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int g[5];
      int p, thr, e, x0, x1;
      {presetn, psel, penable, pwrite, sample_valid, paddr, pwdata, zero_cross} = '0;
      qt = '{default: '0};
      qf = '{default: '0};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         apb(1'b0, ADDR_W'(4 * i), 32'h0);
         `CHK(rd, i == 0 ? {24'h0, THR_RST} : i == 11 ? {16'h0, HCC_RST} : 32'h0)
      end
      foreach (wofs[i])
      begin
         apb(1'b1, wofs[i], 32'hffffffff);
         apb(1'b0, wofs[i], 32'h0);
         `CHK(rd, wexp[i])
      end
      apb(1'b1, 8'h30, 32'h5a5a5a5a);
      apb(1'b0, 8'h30, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, OFS_HCC, 32'h4);
      apb(1'b1, OFS_LCMODE, 32'h40);
      apb(1'b1, OFS_ACCUMULATION_MODE_REGISTER, 32'h0);
      $display("test registers done");
      for (int k = 0; k < 4; k++)
      begin
         thr = 3 + int'(xs() % 4);
         p = 32'h2000000 + int'(xs() % 32'h5ffffff);
         apb(1'b1, OFS_THR, thr);
         set_pwr('{p, p / 2, -p, 0, 0});
         measure(g);
         `CHK(near(g[0], ecnt(p, thr)), 1'b1)
         `CHK(near(g[1], ecnt(p / 2, thr)), 1'b1)
         `CHK(near(g[2], -ecnt(p, thr)), 1'b1)
         `CHK(near(g[3], -ecnt(p, thr)), 1'b1)
         apb(1'b0, OFS_HR0, 32'h0);
         `CHK(near(rd, 0), 1'b1)
      end
      $display("test accumulate done");
      p = 32'h4000000;
      e = ecnt(p, 3);
      apb(1'b1, OFS_THR, 32'h3);
      set_pwr('{-p, 0, 0, 0, 0});
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, OFS_ACCUMULATION_MODE_REGISTER, m << REACTIVE_ACCUMULATION_SELECT_LSB);
         measure(g);
         `CHK(near(g[0], m == ACCM_POS ? 0 : m == ACCM_ABS ? e : -e), 1'b1)
         `CHK(near(g[3], e), 1'b1)
      end
      set_pwr('{0, 0, 0, p, p / 2});
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, OFS_ACCUMULATION_MODE_REGISTER, c << CONNECTION_SELECT_LSB);
         measure(g);
         x0 = c == CON_DELTA ? ecnt(p - p / 2, 3) : c == CON_NEG_A ? -e : 0;
         `CHK(near(g[1], x0), 1'b1)
         `CHK(near(g[4], -x0), 1'b1)
      end
      $display("test modes done");
      apb(1'b1, OFS_ACCUMULATION_MODE_REGISTER, 32'h0);
      set_pwr('{p, 0, 0, 0, 0});
      apb(1'b1, OFS_LCMODE, 32'h0a);
      apb(1'b0, OFS_HR0, 32'h0);
      x0 = rd;
      zx(3'h6, 4);
      apb(1'b0, OFS_HR0, 32'h0);
      `CHK(rd, x0)
      zx(3'h1, 4);
      apb(1'b0, OFS_HR0, 32'h0);
      x1 = rd;
      `CHK(x1 > x0, 1'b1)
      zx(3'h1, 3);
      apb(1'b0, OFS_HR0, 32'h0);
      `CHK(rd, x1)
      zx(3'h1, 1);
      apb(1'b0, OFS_HR0, 32'h0);
      // Fresh period spans fewer cycles than the first one
      `CHK(int'(rd) > 0 && int'(rd) < x1, 1'b1)
      apb(1'b1, OFS_LCMODE, 32'h0);
      apb(1'b0, OFS_HR0, 32'h0);
      x0 = rd;
      repeat (600) @(posedge pclk);
      apb(1'b0, OFS_HR0, 32'h0);
      `CHK(int'(rd) > x0, 1'b1)
      // Negative channels crossed zero earlier, so flags stand
      `CHK(irq_n, 1'b0)
      apb(1'b1, OFS_STATUS, 32'hc);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(irq_n, 1'b1)
      $display("test line cycle done");
      results();
   end
endmodule : reactive_energy_accumulator_test
